// ===== verilog/mwg_pkg.sv
package mwg_pkg;

    // ========================================
    // Register addresses
    localparam logic [7:0] ADDR_TIMER_MASK_TWO   = 8'h24;
    localparam logic [7:0] ADDR_LCD_CTRL         = 8'h2D;
    localparam logic [7:0] ADDR_BLOCK_PROTECT    = 8'h35;
    localparam logic [7:0] ADDR_EEPROM_MAP       = 8'h37;
    localparam logic [7:0] ADDR_OPTIONS_TWO      = 8'h38;
    localparam logic [7:0] ADDR_SYS_OPTIONS      = 8'h39;
    localparam logic [7:0] ADDR_PRIORITY_STATUS  = 8'h3C;
    localparam logic [7:0] ADDR_RAM_MAP          = 8'h3D;

    // ========================================
    // Field masks and bit positions
    localparam logic [7:0] TIMER_GUARD_MASK      = 8'h03;
    localparam int         LCD_ENABLE_BIT        = 0;
    localparam logic [7:0] BLOCK_PROTECT_MASK    = 8'hBF;
    localparam logic [7:0] EEPROM_MAP_MASK       = 8'hFB;
    localparam logic [7:0] OPTIONS_TWO_ONCE_MASK = 8'h03;
    localparam int         OPTIONS_TWO_BIT4      = 4;
    localparam int         FETCH_DRIVE_BIT       = 7;
    localparam logic [7:0] SYS_OPTIONS_GUARD     = 8'h37;
    localparam int         BOOT_ROM_BIT          = 7;
    localparam int         SPECIAL_BIT           = 6;
    localparam int         EXPANDED_BIT          = 5;
    localparam int         MODE_FIELD_LSB        = 5;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_TIMER_MASK_TWO    = 8'h00;
    localparam logic [7:0] RST_LCD_CTRL          = 8'h00;
    localparam logic [7:0] RST_BLOCK_PROTECT     = 8'hBF;
    localparam logic [7:0] RST_EEPROM_MAP        = 8'h00;
    localparam logic [7:0] RST_OPTIONS_TWO       = 8'h00;
    localparam logic [7:0] RST_SYS_OPTIONS       = 8'h10;
    localparam logic [4:0] RST_PRIORITY_SELECT   = 5'h06;
    localparam logic [7:0] RST_RAM_MAP           = 8'h00;
    localparam logic [2:0] RST_MODE_BITS         = 3'h0;

    // ========================================
    // Mode decode: {boot_rom_enable, special_variant, expanded_select}
    localparam logic [2:0] MODE_SINGLE_CHIP      = 3'h0;
    localparam logic [2:0] MODE_EXPANDED         = 3'h1;
    localparam logic [2:0] MODE_BOOTSTRAP        = 3'h6;
    localparam logic [2:0] MODE_TEST             = 3'h3;

    // ========================================
    // Reset vector regions
    localparam logic [15:0] VECTOR_NORMAL        = 16'hFFFA;
    localparam logic [15:0] VECTOR_SPECIAL       = 16'hBFFA;

    // ========================================
    // Early write window
    localparam int         CNT_W                 = 7;
    localparam logic [6:0] WINDOW_CYCLES         = 7'h40;
    localparam logic [6:0] CNT_ONE               = 7'h01;

    // ========================================
    // Write-once flag indices
    localparam int ONCE_TIMER    = 0;
    localparam int ONCE_LCD      = 1;
    localparam int ONCE_PROTECT  = 2;
    localparam int ONCE_EEPROM   = 3;
    localparam int ONCE_OPT_LO   = 4;
    localparam int ONCE_OPT_B4   = 5;
    localparam int ONCE_SYSOPT   = 6;
    localparam int ONCE_RAM_MAP  = 7;
    localparam int ONCE_W        = 8;

    typedef enum logic {
        STRAP_WAIT,
        STRAP_DONE
    } mwg_strap_state_t;

endpackage

// ===== verilog/mwg_mode_if.sv
`timescale 1ns/1ps
interface mwg_mode_if;
    logic strap_valid;
    logic mode_pin_a;
    logic mode_pin_b;
    logic window_open;

    modport src (
        output strap_valid,
        output mode_pin_a,
        output mode_pin_b,
        output window_open
    );
    modport dst (
        input strap_valid,
        input mode_pin_a,
        input mode_pin_b,
        input window_open
    );
endinterface

// ===== verilog/mwg_strap.sv
`timescale 1ns/1ps
module mwg_strap (
    input  wire logic   clk,
    input  wire logic   arst_n,
    input  wire logic   pin_a,
    input  wire logic   pin_b,
    mwg_mode_if.src     mode
);

    // ========================================
    // Pin synchronisers, free running so they track the pins during reset
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] pins;

    assign pins = {pin_b, pin_a};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk) begin
                sync1[g] <= pins[g];
                sync2[g] <= sync1[g];
                sync3[g] <= sync2[g];
            end
        end
    endgenerate

    // ========================================
    // Strap capture and early window counter
    mwg_pkg::mwg_strap_state_t     state;
    mwg_pkg::mwg_strap_state_t     next_state;
    logic                          lat_a;
    logic                          lat_b;
    logic                          next_lat_a;
    logic                          next_lat_b;
    logic [mwg_pkg::CNT_W-1:0]     cnt;
    logic [mwg_pkg::CNT_W-1:0]     next_cnt;

    always_comb begin
        next_state = state;
        next_lat_a = lat_a;
        next_lat_b = lat_b;
        next_cnt   = cnt;
        case (state)
            mwg_pkg::STRAP_WAIT: begin
                // Capture once stages agree, then pins are ignored    // see RULE1
                if (sync2 == sync3) begin
                    next_lat_a = sync3[0];
                    next_lat_b = sync3[1];
                    next_state = mwg_pkg::STRAP_DONE;    // see RULE2
                end
            end
            mwg_pkg::STRAP_DONE: begin
                if (cnt < mwg_pkg::WINDOW_CYCLES) begin
                    next_cnt = cnt + mwg_pkg::CNT_ONE;    // see RULE17
                end
            end
            default: begin
                next_state = mwg_pkg::STRAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= mwg_pkg::STRAP_WAIT;
            lat_a <= 1'b0;
            lat_b <= 1'b1;
            cnt   <= '0;
        end else begin
            state <= next_state;
            lat_a <= next_lat_a;
            lat_b <= next_lat_b;
            cnt   <= next_cnt;
        end
    end

    assign mode.strap_valid = (state == mwg_pkg::STRAP_DONE);
    assign mode.mode_pin_a  = lat_a;
    assign mode.mode_pin_b  = lat_b;
    assign mode.window_open = (state == mwg_pkg::STRAP_DONE)
                            && (cnt < mwg_pkg::WINDOW_CYCLES);    // see RULE17

endmodule

// ===== verilog/mwg_top.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Sample both mode pins around reset release
// RULE2 - Mode pins ignored after capture
// RULE3 - Mode-A pin is open-drain fetch strobe
// RULE4 - Mode-B high: normal vector at top
// RULE5 - Mode-B low: special vector, test access
// RULE6 - Timer mask bits 1:0 guarded early-once
// RULE7 - LCD enable bit accepts one write
// RULE8 - Protect bits clear once early; set anytime
// RULE9 - EEPROM map register accepts one write
// RULE10 - Options-two bits 0,1 once; bit4 normal-once
// RULE11 - System options bits 5,4,2,1,0 early-once
// RULE12 - RAM map register early-once unless special
// RULE13 - Status register layout and reset value
// RULE14 - Mode bits writable only in special variant
// RULE15 - Pin pair decodes to three mode bits
// RULE16 - Special variant cannot be set again
// RULE17 - Count cycles, close window, once flags
module mwg_top (
    input  wire logic          REF_CLK,
    input  wire logic          ARST_N,
    input  wire logic          MODE_PIN_A_IN,
    input  wire logic          MODE_PIN_B_IN,
    input  wire logic          INSTR_FIRST_E,
    output logic               FETCH_STROBE_OUT,
    output logic               FETCH_STROBE_OE,
    input  wire logic [7:0]    BUS_ADDR,
    input  wire logic [7:0]    BUS_WDATA,
    input  wire logic          BUS_WR,
    input  wire logic          BUS_RD,
    output logic [7:0]         BUS_RDATA,
    output logic [15:0]        RESET_VECTOR_BASE,
    output logic               BOOT_ROM_ENABLE,
    output logic               SPECIAL_VARIANT,
    output logic               EXPANDED_SELECT
);

    // ========================================
    // Helpers
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                    input logic [7:0] target);
        wr_hit = wr && (addr == target);
    endfunction

    function automatic logic [2:0] mode_decode(input logic pin_b, input logic pin_a);
        case ({pin_b, pin_a})
            2'h2:    mode_decode = mwg_pkg::MODE_SINGLE_CHIP;
            2'h3:    mode_decode = mwg_pkg::MODE_EXPANDED;
            2'h0:    mode_decode = mwg_pkg::MODE_BOOTSTRAP;
            default: mode_decode = mwg_pkg::MODE_TEST;
        endcase
    endfunction

    // ========================================
    // Strap capture
    mwg_mode_if mode_bus ();

    mwg_strap u_strap (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .pin_a  (MODE_PIN_A_IN),
        .pin_b  (MODE_PIN_B_IN),
        .mode   (mode_bus.src)
    );

    // ========================================
    // Register state
    logic [7:0]                timer_mask_two;
    logic [7:0]                lcd_ctrl_reg;
    logic [7:0]                block_protect_reg;
    logic [7:0]                eeprom_map_reg;
    logic [7:0]                options_two_reg;
    logic [7:0]                sys_options;
    logic [7:0]                priority_and_mode_status;
    logic [7:0]                ram_map;
    logic [mwg_pkg::ONCE_W-1:0] once_used;
    logic                      mode_loaded;
    logic [15:0]               vector_base;

    logic [7:0]                next_timer_mask_two;
    logic [7:0]                next_lcd_ctrl_reg;
    logic [7:0]                next_block_protect_reg;
    logic [7:0]                next_eeprom_map_reg;
    logic [7:0]                next_options_two_reg;
    logic [7:0]                next_sys_options;
    logic [7:0]                next_priority_and_mode_status;
    logic [7:0]                next_ram_map;
    logic [mwg_pkg::ONCE_W-1:0] next_once_used;
    logic                      next_mode_loaded;
    logic [15:0]               next_vector_base;

    logic                      special_variant;
    logic                      early_ok;
    logic [7:0]                wd;

    assign special_variant = priority_and_mode_status[mwg_pkg::SPECIAL_BIT];
    assign wd              = BUS_WDATA;

    // ========================================
    // Register write guard
    always_comb begin
        next_timer_mask_two           = timer_mask_two;
        next_lcd_ctrl_reg             = lcd_ctrl_reg;
        next_block_protect_reg        = block_protect_reg;
        next_eeprom_map_reg           = eeprom_map_reg;
        next_options_two_reg          = options_two_reg;
        next_sys_options              = sys_options;
        next_priority_and_mode_status = priority_and_mode_status;
        next_ram_map                  = ram_map;
        next_once_used                = once_used;
        next_mode_loaded              = mode_loaded;
        next_vector_base              = vector_base;
        early_ok                      = mode_bus.window_open;

        // Load mode bits once the strap is captured
        if (!mode_loaded && mode_bus.strap_valid) begin
            next_mode_loaded = 1'b1;
            next_priority_and_mode_status[7:mwg_pkg::MODE_FIELD_LSB] =
                mode_decode(mode_bus.mode_pin_b, mode_bus.mode_pin_a);    // see RULE15
            if (mode_bus.mode_pin_b) begin
                next_vector_base = mwg_pkg::VECTOR_NORMAL;    // see RULE4
            end else begin
                next_vector_base = mwg_pkg::VECTOR_SPECIAL;    // see RULE5
            end
        end

        // Timer mask: low two bits guarded
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_TIMER_MASK_TWO)) begin
            if (special_variant
                || (early_ok && !once_used[mwg_pkg::ONCE_TIMER])) begin
                next_timer_mask_two = wd;    // see RULE6
                if (!special_variant) begin
                    next_once_used[mwg_pkg::ONCE_TIMER] = 1'b1;
                end
            end else begin
                next_timer_mask_two = (wd & ~mwg_pkg::TIMER_GUARD_MASK)
                                    | (timer_mask_two & mwg_pkg::TIMER_GUARD_MASK);
            end
        end

        // LCD control: enable bit write-once
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_LCD_CTRL)) begin
            next_lcd_ctrl_reg = wd;
            if (once_used[mwg_pkg::ONCE_LCD]) begin
                next_lcd_ctrl_reg[mwg_pkg::LCD_ENABLE_BIT] =
                    lcd_ctrl_reg[mwg_pkg::LCD_ENABLE_BIT];    // see RULE7
            end
            next_once_used[mwg_pkg::ONCE_LCD] = 1'b1;
        end

        // Block protect: set anytime, clear once early or special
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_BLOCK_PROTECT)) begin
            if (special_variant
                || (early_ok && !once_used[mwg_pkg::ONCE_PROTECT])) begin
                next_block_protect_reg = wd & mwg_pkg::BLOCK_PROTECT_MASK;    // see RULE8
                if (!special_variant) begin
                    next_once_used[mwg_pkg::ONCE_PROTECT] = 1'b1;
                end
            end else begin
                next_block_protect_reg = (block_protect_reg | wd)
                                       & mwg_pkg::BLOCK_PROTECT_MASK;    // see RULE8
            end
        end

        // EEPROM map: one write only, no window
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_EEPROM_MAP)
            && !once_used[mwg_pkg::ONCE_EEPROM]) begin
            next_eeprom_map_reg = wd & mwg_pkg::EEPROM_MAP_MASK;    // see RULE9
            next_once_used[mwg_pkg::ONCE_EEPROM] = 1'b1;
        end

        // Options two: bits 0,1 once; bit 4 once in normal modes
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_OPTIONS_TWO)) begin
            next_options_two_reg = wd;
            if (once_used[mwg_pkg::ONCE_OPT_LO]) begin
                next_options_two_reg = (wd & ~mwg_pkg::OPTIONS_TWO_ONCE_MASK)    // see RULE10
                                     | (options_two_reg & mwg_pkg::OPTIONS_TWO_ONCE_MASK);
            end
            next_once_used[mwg_pkg::ONCE_OPT_LO] = 1'b1;
            if (!special_variant) begin
                if (once_used[mwg_pkg::ONCE_OPT_B4]) begin
                    next_options_two_reg[mwg_pkg::OPTIONS_TWO_BIT4] =
                        options_two_reg[mwg_pkg::OPTIONS_TWO_BIT4];    // see RULE10
                end
                next_once_used[mwg_pkg::ONCE_OPT_B4] = 1'b1;
            end
        end

        // System options: guarded bits early-once unless special
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_SYS_OPTIONS)) begin
            if (special_variant
                || (early_ok && !once_used[mwg_pkg::ONCE_SYSOPT])) begin
                next_sys_options = wd;    // see RULE11
                if (!special_variant) begin
                    next_once_used[mwg_pkg::ONCE_SYSOPT] = 1'b1;
                end
            end else begin
                next_sys_options = (wd & ~mwg_pkg::SYS_OPTIONS_GUARD)
                                 | (sys_options & mwg_pkg::SYS_OPTIONS_GUARD);
            end
        end

        // RAM map: whole register early-once unless special
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_RAM_MAP)
            && (special_variant
                || (early_ok && !once_used[mwg_pkg::ONCE_RAM_MAP]))) begin
            next_ram_map = wd;    // see RULE12
            if (!special_variant) begin
                next_once_used[mwg_pkg::ONCE_RAM_MAP] = 1'b1;
            end
        end

        // Status register: priority field once mode bits loaded, mode field in special only
        if (wr_hit(BUS_WR, BUS_ADDR, mwg_pkg::ADDR_PRIORITY_STATUS) && mode_loaded) begin
            next_priority_and_mode_status[4:0] = wd[4:0];    // see RULE13
            if (special_variant) begin
                // Special bit can only fall here, never rise again
                next_priority_and_mode_status[7:mwg_pkg::MODE_FIELD_LSB] =
                    wd[7:mwg_pkg::MODE_FIELD_LSB];    // see RULE14
                next_priority_and_mode_status[mwg_pkg::SPECIAL_BIT] =
                    wd[mwg_pkg::SPECIAL_BIT] & special_variant;    // see RULE16
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            timer_mask_two           <= mwg_pkg::RST_TIMER_MASK_TWO;
            lcd_ctrl_reg             <= mwg_pkg::RST_LCD_CTRL;
            block_protect_reg        <= mwg_pkg::RST_BLOCK_PROTECT;
            eeprom_map_reg           <= mwg_pkg::RST_EEPROM_MAP;
            options_two_reg          <= mwg_pkg::RST_OPTIONS_TWO;
            sys_options              <= mwg_pkg::RST_SYS_OPTIONS;
            priority_and_mode_status <= {mwg_pkg::RST_MODE_BITS,
                                         mwg_pkg::RST_PRIORITY_SELECT};    // see RULE13
            ram_map                  <= mwg_pkg::RST_RAM_MAP;
            once_used                <= '0;    // see RULE17
            mode_loaded              <= 1'b0;
            vector_base              <= mwg_pkg::VECTOR_NORMAL;
        end else begin
            timer_mask_two           <= next_timer_mask_two;
            lcd_ctrl_reg             <= next_lcd_ctrl_reg;
            block_protect_reg        <= next_block_protect_reg;
            eeprom_map_reg           <= next_eeprom_map_reg;
            options_two_reg          <= next_options_two_reg;
            sys_options              <= next_sys_options;
            priority_and_mode_status <= next_priority_and_mode_status;
            ram_map                  <= next_ram_map;
            once_used                <= next_once_used;
            mode_loaded              <= next_mode_loaded;
            vector_base              <= next_vector_base;
        end
    end

    // ========================================
    // Read port and pin outputs
    logic [7:0] next_rdata;
    logic       next_strobe_oe;

    always_comb begin
        next_rdata = '0;
        if (BUS_RD) begin
            case (BUS_ADDR)
                mwg_pkg::ADDR_TIMER_MASK_TWO:  next_rdata = timer_mask_two;
                mwg_pkg::ADDR_LCD_CTRL:        next_rdata = lcd_ctrl_reg;
                mwg_pkg::ADDR_BLOCK_PROTECT:   next_rdata = block_protect_reg;
                mwg_pkg::ADDR_EEPROM_MAP:      next_rdata = eeprom_map_reg;
                mwg_pkg::ADDR_OPTIONS_TWO:     next_rdata = options_two_reg;
                mwg_pkg::ADDR_SYS_OPTIONS:     next_rdata = sys_options;
                mwg_pkg::ADDR_PRIORITY_STATUS: next_rdata = priority_and_mode_status;
                mwg_pkg::ADDR_RAM_MAP:         next_rdata = ram_map;
                default:                       next_rdata = '0;
            endcase
        end
        // Open-drain strobe pulls low only after the strap is taken
        next_strobe_oe = mode_bus.strap_valid
                       && options_two_reg[mwg_pkg::FETCH_DRIVE_BIT]
                       && INSTR_FIRST_E;    // see RULE3
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            BUS_RDATA         <= '0;
            FETCH_STROBE_OE   <= 1'b0;
            FETCH_STROBE_OUT  <= 1'b0;
            RESET_VECTOR_BASE <= mwg_pkg::VECTOR_NORMAL;
            BOOT_ROM_ENABLE   <= 1'b0;
            SPECIAL_VARIANT   <= 1'b0;
            EXPANDED_SELECT   <= 1'b0;
        end else begin
            BUS_RDATA         <= next_rdata;
            FETCH_STROBE_OE   <= next_strobe_oe;
            FETCH_STROBE_OUT  <= 1'b0;
            RESET_VECTOR_BASE <= vector_base;
            BOOT_ROM_ENABLE   <= priority_and_mode_status[mwg_pkg::BOOT_ROM_BIT];
            SPECIAL_VARIANT   <= special_variant;
            EXPANDED_SELECT   <= priority_and_mode_status[mwg_pkg::EXPANDED_BIT];
        end
    end

endmodule

// ===== testbench/mwg_monitor.sv
`timescale 1ns/1ps
module mwg_monitor (
    input wire logic        REF_CLK,
    input wire logic        ARST_N,
    input wire logic        INSTR_FIRST_E,
    input wire logic        FETCH_STROBE_OUT,
    input wire logic        FETCH_STROBE_OE,
    input wire logic [7:0]  BUS_ADDR,
    input wire logic        BUS_RD,
    input wire logic [7:0]  BUS_RDATA,
    input wire logic [15:0] RESET_VECTOR_BASE,
    input wire logic        BOOT_ROM_ENABLE,
    input wire logic        SPECIAL_VARIANT,
    input wire logic        EXPANDED_SELECT
);
    // ========
    // Edges since reset release
    logic [3:0] up;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            up <= 4'h0;
        end else if (up != 4'hF) begin
            up <= up + 4'h1;
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    property p_rd_idle; !$past(BUS_RD) |-> BUS_RDATA == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_strobe_low; FETCH_STROBE_OUT == 1'b0; endproperty
    a_strobe_low: assert property (p_strobe_low) else $error("strobe drives high");
    property p_oe_cause; FETCH_STROBE_OE |-> $past(INSTR_FIRST_E); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("strobe without fetch");
    property p_decode;
        up == 4'h4 |-> ({BOOT_ROM_ENABLE, SPECIAL_VARIANT, EXPANDED_SELECT} inside {3'h0, 3'h1,
            3'h6, 3'h3}) && ((RESET_VECTOR_BASE == 16'hBFFA) == SPECIAL_VARIANT);
    endproperty
    a_decode: assert property (p_decode) else $error("bad decode");
    property p_vec_hold; up >= 4'h4 |-> $stable(RESET_VECTOR_BASE); endproperty
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
    property p_no_rise; up >= 4'h4 |-> !$rose(SPECIAL_VARIANT); endproperty
    a_no_rise: assert property (p_no_rise) else $error("special set again");
    property p_status_bits;
        BUS_RD && BUS_ADDR == 8'h3C && up >= 4'h6 |=>
            BUS_RDATA[7:5] == {BOOT_ROM_ENABLE, SPECIAL_VARIANT, EXPANDED_SELECT};
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits mismatch");
    property p_prot_b6; BUS_RD && BUS_ADDR == 8'h35 ##1 1'b1 |-> !BUS_RDATA[6]; endproperty
    a_prot_b6: assert property (p_prot_b6) else $error("protect bit6 set");
    property p_eemap_b2; BUS_RD && BUS_ADDR == 8'h37 |=> BUS_RDATA[2] == 1'b0; endproperty
    a_eemap_b2: assert property (p_eemap_b2) else $error("map bit2 set");
endmodule
bind mwg_top mwg_monitor u_mon (.REF_CLK, .ARST_N, .INSTR_FIRST_E, .FETCH_STROBE_OUT,
    .FETCH_STROBE_OE, .BUS_ADDR, .BUS_RD, .BUS_RDATA, .RESET_VECTOR_BASE, .BOOT_ROM_ENABLE,
    .SPECIAL_VARIANT, .EXPANDED_SELECT);

// ===== testbench/mwg_pin_model.sv
`timescale 1ns/1ps
module mwg_pin_model (
    input  wire logic strap_a,
    input  wire logic strap_b,
    input  wire logic oe,
    input  wire logic drv,
    output logic      pin_a,
    output logic      pin_b
);
    // Open-drain strobe over board strap level
    assign pin_a = oe ? drv : strap_a;
    assign pin_b = strap_b;
endmodule

// ===== testbench/mode_select_and_init_write_guard_bench.sv
`timescale 1ns/1ps
module mode_select_and_init_write_guard_bench;
    logic        clk = 1'b0, arst_n = 1'b0, strap_a = 1'b0, strap_b = 1'b1, ife = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, pin_a, pin_b, st_out, st_oe, boot, spec, expd, late, sp;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d, wd, ad, mdl [0:255];
    logic [7:0]  regs [0:6] = '{8'h24, 8'h2D, 8'h35, 8'h37, 8'h38, 8'h39, 8'h3D};
    logic [2:0]  em;
    logic [15:0] vec;
    logic [31:0] seed = 32'h8FC2C24B;
    int          fail_count = 0, n_checks = 0;
    always #2 clk = ~clk;
    mwg_pin_model u_pins (.strap_a(strap_a), .strap_b(strap_b), .oe(st_oe), .drv(st_out),
        .pin_a(pin_a), .pin_b(pin_b));
    mwg_top u_dut (.REF_CLK(clk), .ARST_N(arst_n), .MODE_PIN_A_IN(pin_a), .MODE_PIN_B_IN(pin_b),
        .INSTR_FIRST_E(ife), .FETCH_STROBE_OUT(st_out), .FETCH_STROBE_OE(st_oe),
        .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata),
        .RESET_VECTOR_BASE(vec), .BOOT_ROM_ENABLE(boot), .SPECIAL_VARIANT(spec),
        .EXPANDED_SELECT(expd));
    // ========
    // Expectation helpers
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:8] ^ seed[7:0];
    endfunction
    function automatic logic [7:0] exp_reg(logic [7:0] a, logic [7:0] o, logic [7:0] w, logic f);
        logic g;
        g = sp || (!late && f);
        case (a)
            8'h24: return g ? w : (w & 8'hFC) | (o & 8'h03);
            8'h39: return g ? w : (w & 8'hC8) | (o & 8'h37);
            8'h3D: return g ? w : o;
            8'h35: return (g ? w : (w | o)) & 8'hBF;
            8'h37: return f ? (w & 8'hFB) : o;
            8'h2D: return {w[7:1], f ? w[0] : o[0]};
            default: return {w[7:5], (f || sp) ? w[4] : o[4], w[3:2], f ? w[1:0] : o[1:0]};
        endcase
    endfunction
    // ========
    // Bus and checking tasks
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic idle(int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] w);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= w;
        @(posedge clk);
    endtask
    task automatic rd_reg(logic [7:0] a);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic do_reset(logic b, logic a);
        arst_n <= 1'b0;
        strap_a <= a;
        strap_b <= b;
        idle(10);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (mdl[i]) mdl[i] = 8'h00;
        mdl[8'h35] = mwg_pkg::RST_BLOCK_PROTECT;
        mdl[8'h39] = mwg_pkg::RST_SYS_OPTIONS;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========
    // Main sequence: every strap pair, inside and after the early window
    initial begin
        for (int m = 0; m < 8; m++) begin
            late = m[2];
            do_reset(m[1], m[0]);
            em = m[1] ? (m[0] ? 3'h1 : 3'h0) : (m[0] ? 3'h3 : 3'h6);
            sp = em[1];
            chk("mode", {13'h0, em}, {13'h0, boot, spec, expd});
            chk("vector", m[1] ? 16'hFFFA : 16'hBFFA, vec);
            strap_a <= ~m[0];
            strap_b <= ~m[1];
            rd_reg(8'h3C);
            chk("status", {8'h00, em, 5'h06}, {8'h00, d});
            mdl[8'h3C] = {em, 5'h06};
            if (late) idle(70);
            for (int i = 0; i < 7; i++) begin
                ad = regs[i];
                rd_reg(ad);
                chk("reset_value", {8'h00, mdl[ad]}, {8'h00, d});
                for (int k = 0; k < 2; k++) begin
                    wd = rnd();
                    mdl[ad] = exp_reg(ad, mdl[ad], wd, k == 0);
                    wr_reg(ad, wd);
                end
                rd_reg(ad);
                chk("guarded", {8'h00, mdl[ad]}, {8'h00, d});
            end
            idle(1);
            ife <= 1'b1;
            @(posedge clk);
            ife <= 1'b0;
            @(posedge clk);
            chk("strobe_oe", {15'h0, mdl[8'h38][7]}, {15'h0, st_oe});
            chk("held_mode", {13'h0, em}, {13'h0, boot, spec, expd});
            wr_reg(8'h00, rnd());
            rd_reg(8'h00);
            chk("unmapped", 16'h0000, {8'h00, d});
            for (int k = 0; k < 2; k++) begin
                wd = k ? (rnd() | 8'h40) : (rnd() & 8'hBF);
                mdl[8'h3C] = {mdl[8'h3C][6] ? wd[7:5] : mdl[8'h3C][7:5], wd[4:0]};
                wr_reg(8'h3C, wd);
                rd_reg(8'h3C);
                chk("status_wr", {8'h00, mdl[8'h3C]}, {8'h00, d});
            end
            idle(2);
            chk("special_out", {15'h0, mdl[8'h3C][6]}, {15'h0, spec});
            $display("test %0d done", m);
        end
        conclude();
    end
    initial begin
        repeat (50000) @(posedge clk);
        fail_count++;
        conclude();
    end
endmodule
